// File: design/irq_gate_pkg.sv
// package for the interrupt acceptance gating block
// assumes a single 200 MHz clock and an AXI4-Lite register bus
package irq_gate_pkg;
  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int N_INPUT   = 6;
  localparam int N_TIMER   = 3;
  localparam int N_COUNTER = 6;
  localparam int N_SRC     = N_INPUT + N_TIMER + N_COUNTER;
  localparam int N_FLAG    = N_INPUT + N_TIMER + 1;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] MASK_OFS    = 12'h004;
  localparam logic [11:0] STATUS_OFS  = 12'h008;
  localparam logic [11:0] ACCEPT_OFS  = 12'h00c;
  localparam int          CTRL_RUN    = 0;
  localparam int          STAT_GEN    = 0;
  localparam int          STAT_PEND   = 1;
  localparam int          STAT_RUN    = 2;
  localparam int          CNT_FLAG    = N_INPUT + N_TIMER;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [N_FLAG-1:0] MASK_RST = '0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [N_COUNTER-1:0] counter;
    logic [N_TIMER-1:0]   timer;
    logic [N_INPUT-1:0]   input_src;
  } irq_vec_s;

  typedef struct packed {
    logic        enable_instr;
    logic        disable_instr;
  } global_instr_s;
endpackage

// File: design/irq_accept_core.sv
// per-source acceptance and pending latch with global enable deferral
// assumes same-clock inputs; masks already expanded per source
`timescale 1ns/1ps
module irq_accept_core
  import irq_gate_pkg::*;
#(
  parameter int N = N_SRC
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] masked,
  input  wire logic         global_en,
  input  wire logic [N-1:0] take,
  output logic      [N-1:0] pending,
  output logic      [N-1:0] service
);
  // ****************************************************************
  // pending latch
  // ****************************************************************
  logic [N-1:0] pend_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= '0;
    end else begin
      // new acceptance wins over the handler taking it
      pend_r <= (pend_r & ~take) | (req & ~masked);
    end
  end

  assign pending = pend_r;
  // masked sources never reach service, even with global enable on
  assign service = global_en ? (pend_r & ~masked) : '0;
endmodule

// File: design/interrupt_accept_gating.sv
// top of the interrupt acceptance gating block with AXI4-Lite registers
// assumes interrupt requests arrive from pins and are synchronised here
`timescale 1ns/1ps
// What this block does
// - each input and timer source has its own disable flag, bit 0 first
// - a request from a source with its flag set runs no handler
// - per-source mask overrides the global enable
// - a request from an unmasked source is accepted when it occurs
// - accepted request starts its handler at once when globally enabled
// - under global disable, accepted requests wait for global enable
// - one counter flag masks all six counter sources together
// - leaving run for stop clears every disable flag
module interrupt_accept_gating
  import irq_gate_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire irq_vec_s          irq_req_pin,
  input  wire global_instr_s     global_instr,
  input  wire logic [N_SRC-1:0]  handler_take,
  output logic [N_SRC-1:0]       handler_start,
  output logic                   global_irq_on
);
  // ****************************************************************
  // pin synchronisers and edge detect
  // ****************************************************************
  logic [N_SRC-1:0] sync1_r;
  logic [N_SRC-1:0] sync2_r;
  logic [N_SRC-1:0] sync3_r;
  logic [N_SRC-1:0] req_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= irq_req_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a request is its rising edge; a held level counts once
  assign req_edge = sync2_r & ~sync3_r;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic              run_r;
  logic [N_FLAG-1:0] mask_r;
  logic [N_FLAG-1:0] mask_nxt;
  logic              gen_r;
  logic [N_SRC-1:0]  pending;
  logic [N_SRC-1:0]  accept_r;
  logic [N_SRC-1:0]  src_mask;
  logic              wr_go;
  logic              aw_got_r;
  logic              w_got_r;
  logic [11:0]       awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              wr_ok;
  logic              run_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // axi write channel
  // ****************************************************************
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign wr_go         = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_got_r <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    if (awaddr_r[11:2] == CTRL_OFS[11:2]) begin
      wr_ok = 1'b1;
    end else if (awaddr_r[11:2] == MASK_OFS[11:2]) begin
      wr_ok = 1'b1;
    end else if (awaddr_r[11:2] == STATUS_OFS[11:2]) begin
      wr_ok = 1'b1;
    end else if (awaddr_r[11:2] == ACCEPT_OFS[11:2]) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // run mode and disable flags
  // ****************************************************************
  always_comb begin
    run_nxt  = run_r;
    mask_nxt = mask_r;
    if (wr_go && awaddr_r[11:2] == CTRL_OFS[11:2]) begin
      run_nxt = merge({31'h0, run_r}, wdata_r, wstrb_r)[CTRL_RUN];
    end
    if (wr_go && awaddr_r[11:2] == MASK_OFS[11:2]) begin
      mask_nxt = merge({{(32-N_FLAG){1'b0}}, mask_r}, wdata_r,
                       wstrb_r)[N_FLAG-1:0];
    end
    if (run_r && !run_nxt) begin
      mask_nxt = MASK_RST;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r  <= 1'b0;
      mask_r <= MASK_RST;
    end else begin
      run_r  <= run_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ****************************************************************
  // global enable state
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_r <= 1'b0;
    end else if (global_instr.disable_instr) begin
      // disable wins if both arrive together: the safer choice
      gen_r <= 1'b0;
    end else if (global_instr.enable_instr) begin
      gen_r <= 1'b1;
    end
  end

  assign global_irq_on = gen_r;

  // ****************************************************************
  // per-source masks and acceptance
  // ****************************************************************
  assign src_mask = {{N_COUNTER{mask_r[CNT_FLAG]}},
                     mask_r[CNT_FLAG-1:0]};

  irq_accept_core #(
    .N (N_SRC)
  ) u_core (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .req       (req_edge),
    .masked    (src_mask),
    .global_en (gen_r),
    .take      (handler_take),
    .pending   (pending),
    .service   (handler_start)
  );

  // sticky record of accepted sources, cleared by writing ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accept_r <= '0;
    end else begin
      if (wr_go && awaddr_r[11:2] == ACCEPT_OFS[11:2]) begin
        accept_r <= (accept_r & ~wdata_r[N_SRC-1:0]) | (req_edge & ~src_mask);
      end else begin
        accept_r <= accept_r | (req_edge & ~src_mask);
      end
    end
  end

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr[11:2] == CTRL_OFS[11:2]) begin
        s_axi_rdata <= {31'h0, run_r};
      end else if (s_axi_araddr[11:2] == MASK_OFS[11:2]) begin
        s_axi_rdata <= {{(32-N_FLAG){1'b0}}, mask_r};
      end else if (s_axi_araddr[11:2] == STATUS_OFS[11:2]) begin
        s_axi_rdata <= {29'h0, run_r, |pending, gen_r};
      end else if (s_axi_araddr[11:2] == ACCEPT_OFS[11:2]) begin
        s_axi_rdata <= {{(32-N_SRC){1'b0}}, accept_r};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: testbench/irq_gate_chk.sv
// assertions on the ports of the interrupt acceptance gating block
// assumes one clock and the package of the block
`timescale 1ns/1ps
module irq_gate_chk
  import irq_gate_pkg::*;
(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire global_instr_s    global_instr,
  input wire logic [N_SRC-1:0] handler_start,
  input wire logic             global_irq_on
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_start_gen_on: assert property (|handler_start |-> global_irq_on)
    else $error("handler start while globally off");
  chk_disable_wins: assert property (global_instr.disable_instr
    |=> !global_irq_on && handler_start == '0)
    else $error("global disable not honoured");
  chk_enable_sets: assert property (global_instr == 2'h2 |=> global_irq_on)
    else $error("global enable not honoured");
  chk_gen_steady: assert property (global_instr == 2'h0
    |=> $stable(global_irq_on))
    else $error("global state moved with no pulse");
  chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_busy: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response open");
endmodule
bind interrupt_accept_gating irq_gate_chk u_irq_gate_chk (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .global_instr, .handler_start,
  .global_irq_on
);

// File: testbench/irq_partner.sv
// model of interrupt pins, timers and program executor
// assumes fire and ack_en come from the bench on the clock
`timescale 1ns/1ps
module irq_partner
  import irq_gate_pkg::*;
(
  input  wire logic [N_SRC-1:0] fire,
  input  wire logic             aclk,
  input  wire logic             ack_en,
  input  wire logic [N_SRC-1:0] handler_start,
  output irq_vec_s              irq_req_pin,
  output logic      [N_SRC-1:0] handler_take
);
  logic [2:0] hold;
  initial begin
    irq_req_pin = '0;
    handler_take = '0;
    hold = '0;
  end
  // pins move on the falling edge: the block must treat them as async
  always @(negedge aclk) begin
    if (|fire) begin
      irq_req_pin <= fire;
      hold <= 3'h4;
    end else if (hold != 3'h0) hold <= hold - 3'h1;
    else irq_req_pin <= '0;
  end
  // executor takes only what was started; ack_en lets it take, and it takes nothing while ack_en is low
  always @(posedge aclk)
    handler_take <= ack_en ? handler_start & ~handler_take : '0;
endmodule

// File: testbench/interrupt_accept_gating_tb.sv
// self-checking bench for the interrupt acceptance gating block
// assumes irq_partner stands in for pins, timers and executor
`timescale 1ns/1ps
module interrupt_accept_gating_tb;
  import irq_gate_pkg::*;
  logic              aclk, aresetn, ack_en, global_irq_on;
  logic [11:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  irq_vec_s          irq_req_pin;
  global_instr_s     global_instr;
  logic [N_SRC-1:0]  handler_take, handler_start, fire;
  logic [N_FLAG-1:0] m;
  int                n_fail, comparisons, seed;
  interrupt_accept_gating u_interrupt_accept_gating (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq_req_pin, .global_instr,
    .handler_take, .handler_start, .global_irq_on
  );
  irq_partner u_irq_partner (
    .aclk, .fire, .ack_en, .handler_start, .irq_req_pin, .handler_take
  );
  // ****
  // helpers
  // ****
  function automatic logic [N_SRC-1:0] acc(input logic [N_FLAG-1:0] f);
    return ~{{N_COUNTER{f[CNT_FLAG]}}, f[CNT_FLAG-1:0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    comparisons++;
    if (seen !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 64) begin
      n_fail++;
      report_and_stop;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      step(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      step(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata, e);
    check(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic pulse(input logic [1:0] v, input logic [N_SRC-1:0] f);
    global_instr <= v;
    fire <= f;
    @(posedge aclk);
    global_instr <= 2'h0;
    fire <= '0;
    repeat (8) @(posedge aclk);
  endtask
  task automatic ack_all;
    ack_en <= 1'b1;
    repeat (4) @(posedge aclk);
    ack_en <= 1'b0;
    @(posedge aclk);
    check(handler_start, 32'h0);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, ack_en, aresetn} = '0;
    s_axi_wstrb = 4'hf;
    global_instr = 2'h0;
    fire = '0;
    seed = 2;
    n_fail = 0;
    comparisons = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(MASK_OFS, 32'h0, RESP_OKAY);
    rdchk(12'h010, 32'h0, RESP_SLVERR);
    wr(12'h010, 32'h1, RESP_SLVERR);
    wr(STATUS_OFS, 32'h7, RESP_OKAY);
    rdchk(STATUS_OFS, 32'h0, RESP_OKAY);
    $display("test registers done");
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    pulse(2'h2, '0);
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 10'h001 : (i == 1) ? 10'h200 : 10'($random(seed));
      wr(MASK_OFS, {22'h0, m}, RESP_OKAY);
      rdchk(MASK_OFS, {22'h0, m}, RESP_OKAY);
      pulse(2'h0, '1);
      check(handler_start, acc(m));
      rdchk(ACCEPT_OFS, acc(m), RESP_OKAY);
      wr(MASK_OFS, 32'h0, RESP_OKAY);
      check(handler_start, acc(m));
      ack_all;
      wr(ACCEPT_OFS, 32'h7fff, RESP_OKAY);
    end
    $display("test masking done");
    pulse(2'h3, '0);
    pulse(2'h0, 15'h0001);
    check(handler_start, 32'h0);
    rdchk(STATUS_OFS, 32'h6, RESP_OKAY);
    pulse(2'h2, '0);
    check(handler_start, 32'h1);
    ack_all;
    $display("test deferral done");
    wr(MASK_OFS, 32'h3ff, RESP_OKAY);
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    rdchk(MASK_OFS, 32'h0, RESP_OKAY);
    $display("test stop done");
    report_and_stop;
  end
endmodule
